/* File: logic/servo_io_signal_allocator.sv */
// Behaviour
// - Each input function has a 4-bit selector: 0-6 take pins 13,7,8,9,10,11,12 at the default level, 9-F the same pins inverted, 7 forces active and 8 forces inactive.
// - Latch triggers route only from pins 10, 11, 12 or are forced by 7 or 8; any other code leaves them inactive.
// - Latch codes 4-6 are low-active and D-F high-active on pins 10 to 12.
// - A pin selected by several functions drives all of them at once, each through its own active level.
// - Each of nine status functions has a 2-bit route: 0 unused, 1 pair 1(2), 2 pair 23(24), 3 pair 25(26).
// - A pair carrying several status functions shows their OR.
// - A status function not evaluated in the present control mode counts as inactive.
// - Each pair has an inversion bit applied after the OR, cleared by default.
//
// Design decisions made here: the register offsets and the APB register port.
`include "servo_io_params.svh"

module servo_io_signal_allocator (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Connector input pins 13,7,8,9,10,11,12 in bits 0 to 6.
	input wire servo_io_pkg::pins_t seq_in,
	// Drive status: position_done, speed_match, rotating, ready, torque_limited,
	// speed_limited, brake_release, warning, near in bits 0 to 8.
	input wire servo_io_pkg::status_t status_in,
	// Routed input functions, high when active.
	output logic forward_overtravel_in,
	output logic reverse_overtravel_in,
	output logic forward_torque_clamp_in,
	output logic reverse_torque_clamp_in,
	output logic homing_slowdown_in,
	output logic latch_trigger_1,
	output logic latch_trigger_2,
	output logic latch_trigger_3,
	// Output pin pairs 1(2), 23(24), 25(26) in bits 0 to 2.
	output logic [2:0] seq_out
);
	import servo_io_pkg::*;

	pins_t pin_level;
	logic [31:0] input_select;
	logic [31:0] status_route_group_a;
	logic [31:0] status_route_group_b;
	logic [31:0] near_route_selector;
	logic [31:0] output_inversion_bits;
	logic [31:0] control_mode;
	logic [31:0] next_input_select;
	logic [31:0] next_status_route_group_a;
	logic [31:0] next_status_route_group_b;
	logic [31:0] next_near_route_selector;
	logic [31:0] next_output_inversion_bits;
	logic [31:0] next_control_mode;
	logic [31:0] next_prdata;
	logic [7:0] func;
	logic [7:0] next_func;
	logic [2:0] next_seq_out;
	status_t status_valid;
	logic [17:0] routes;
	logic addr_hit;
	logic wr_access;
	logic rd_setup;

	pin_synchroniser u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_raw(seq_in),
		.pin_level(pin_level)
	);

	// Masks a register write with the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Decodes one input selector against the synchronised pins.
	function automatic logic route_input(input in_code_t code, input pins_t pins, input logic high_default,
		input logic latch_only);
		logic lvl;
		logic res;
		lvl = 1'b0;
		res = 1'b0;
		if (code == `CODE_FORCE_ON) begin
			res = 1'b1;
		end else if (code == `CODE_FORCE_OFF) begin
			res = 1'b0;
		end else if (code < `CODE_FORCE_ON) begin
			lvl = pins[code[2:0]];
			if (latch_only && code < `CODE_LATCH_LOW_FIRST) begin
				res = 1'b0;
			end else begin
				res = high_default ? lvl : ~lvl;
			end
		end else begin
			lvl = pins[3'(code - `CODE_INVERT_BASE)];
			if (latch_only && code < `CODE_LATCH_HIGH_FIRST) begin
				res = 1'b0;
			end else begin
				res = high_default ? ~lvl : lvl;
			end
		end
		return res;
	endfunction

	// Bus decode.
	always_comb begin
		case (paddr)
			`ADDR_INPUT_SELECT, `ADDR_STATUS_ROUTE_GROUP_A, `ADDR_STATUS_ROUTE_GROUP_B,
			`ADDR_NEAR_ROUTE_SELECTOR, `ADDR_OUTPUT_INVERSION_BITS, `ADDR_CONTROL_MODE,
			`ADDR_IO_STATE: begin
				addr_hit = 1'b1;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;
	assign wr_access = psel && penable && pwrite && addr_hit;
	assign rd_setup = psel && !penable && !pwrite;

	// Configuration registers.
	always_comb begin
		next_input_select = input_select;
		next_status_route_group_a = status_route_group_a;
		next_status_route_group_b = status_route_group_b;
		next_near_route_selector = near_route_selector;
		next_output_inversion_bits = output_inversion_bits;
		next_control_mode = control_mode;
		if (wr_access) begin
			case (paddr)
				`ADDR_INPUT_SELECT: begin
					next_input_select = merge(input_select, pwdata, pstrb);
				end
				`ADDR_STATUS_ROUTE_GROUP_A: begin
					next_status_route_group_a = merge(status_route_group_a, pwdata, pstrb) & 32'h000000FF;
				end
				`ADDR_STATUS_ROUTE_GROUP_B: begin
					next_status_route_group_b = merge(status_route_group_b, pwdata, pstrb) & 32'h000000FF;
				end
				`ADDR_NEAR_ROUTE_SELECTOR: begin
					next_near_route_selector = merge(near_route_selector, pwdata, pstrb) & 32'h00000003;
				end
				`ADDR_OUTPUT_INVERSION_BITS: begin
					next_output_inversion_bits = merge(output_inversion_bits, pwdata, pstrb) & 32'h00000007;
				end
				`ADDR_CONTROL_MODE: begin
					next_control_mode = merge(control_mode, pwdata, pstrb) & 32'h00000003;
				end
				`ADDR_IO_STATE: begin
					next_control_mode = control_mode;
				end
				default: begin
					next_control_mode = control_mode;
				end
			endcase
		end
	end

	// Read data, captured in the setup phase.
	always_comb begin
		next_prdata = prdata;
		if (rd_setup) begin
			case (paddr)
				`ADDR_INPUT_SELECT: begin
					next_prdata = input_select;
				end
				`ADDR_STATUS_ROUTE_GROUP_A: begin
					next_prdata = status_route_group_a;
				end
				`ADDR_STATUS_ROUTE_GROUP_B: begin
					next_prdata = status_route_group_b;
				end
				`ADDR_NEAR_ROUTE_SELECTOR: begin
					next_prdata = near_route_selector;
				end
				`ADDR_OUTPUT_INVERSION_BITS: begin
					next_prdata = output_inversion_bits;
				end
				`ADDR_CONTROL_MODE: begin
					next_prdata = control_mode;
				end
				`ADDR_IO_STATE: begin
					next_prdata = 32'h00000000;
					next_prdata[`IO_STATE_PINS_LSB +: 7] = pin_level;
					next_prdata[`IO_STATE_FUNCS_LSB +: 8] = func;
					next_prdata[`IO_STATE_OUTS_LSB +: 3] = seq_out;
				end
				default: begin
					next_prdata = 32'h00000000;
				end
			endcase
		end
	end

	// Input function routing.
	genvar f;
	generate
		for (f = 0; f < 8; f = f + 1) begin : g_func
			always_comb begin
				next_func[f] = route_input(input_select[f*4 +: 4], pin_level, (f < 2), (f >= 5));
			end
		end
	endgenerate

	// Status functions not evaluated in the present mode are inactive.
	always_comb begin
		status_valid = 9'h1FF;
		case (control_mode_t'(control_mode[1:0]))
			MODE_POSITION: begin
				status_valid[1] = 1'b0;
				status_valid[5] = 1'b0;
			end
			MODE_SPEED: begin
				status_valid[0] = 1'b0;
				status_valid[8] = 1'b0;
				status_valid[5] = 1'b0;
			end
			MODE_TORQUE: begin
				status_valid[0] = 1'b0;
				status_valid[1] = 1'b0;
				status_valid[8] = 1'b0;
			end
			default: begin
				status_valid = 9'h1FF;
			end
		endcase
	end

	assign routes = {near_route_selector[1:0], status_route_group_b[7:0], status_route_group_a[7:0]};

	// Output pair combining and polarity.
	always_comb begin
		next_seq_out = 3'h0;
		for (int p = 0; p < 3; p++) begin
			for (int s = 0; s < 9; s++) begin
				if (routes[s*2 +: 2] == 2'(p + 1) && status_valid[s] && status_in[s]) begin
					next_seq_out[p] = 1'b1;
				end
			end
			next_seq_out[p] = next_seq_out[p] ^ output_inversion_bits[p];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_select <= `RST_INPUT_SELECT;
			status_route_group_a <= `RST_STATUS_ROUTE_GROUP_A;
			status_route_group_b <= `RST_STATUS_ROUTE_GROUP_B;
			near_route_selector <= `RST_NEAR_ROUTE_SELECTOR;
			output_inversion_bits <= `RST_OUTPUT_INVERSION_BITS;
			control_mode <= `RST_CONTROL_MODE;
			prdata <= 32'h00000000;
		end else begin
			input_select <= next_input_select;
			status_route_group_a <= next_status_route_group_a;
			status_route_group_b <= next_status_route_group_b;
			near_route_selector <= next_near_route_selector;
			output_inversion_bits <= next_output_inversion_bits;
			control_mode <= next_control_mode;
			prdata <= next_prdata;
		end
	end

	// Routed functions and pin pairs, refreshed on every clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func <= 8'h00;
			seq_out <= 3'h0;
		end else begin
			func <= next_func;
			seq_out <= next_seq_out;
		end
	end

	// Function outputs.
	assign forward_overtravel_in = func[0];
	assign reverse_overtravel_in = func[1];
	assign forward_torque_clamp_in = func[2];
	assign reverse_torque_clamp_in = func[3];
	assign homing_slowdown_in = func[4];
	assign latch_trigger_1 = func[5];
	assign latch_trigger_2 = func[6];
	assign latch_trigger_3 = func[7];
endmodule

/* File: logic/servo_io_params.svh */
`ifndef SERVO_IO_PARAMS_SVH
`define SERVO_IO_PARAMS_SVH

// Register byte addresses.
`define ADDR_INPUT_SELECT 12'h000
`define ADDR_STATUS_ROUTE_GROUP_A 12'h004
`define ADDR_STATUS_ROUTE_GROUP_B 12'h008
`define ADDR_NEAR_ROUTE_SELECTOR 12'h00C
`define ADDR_OUTPUT_INVERSION_BITS 12'h010
`define ADDR_CONTROL_MODE 12'h014
`define ADDR_IO_STATE 12'h018

// Field positions.
`define IN_SEL_WIDTH 4
`define ROUTE_WIDTH 2
`define IO_STATE_PINS_LSB 0
`define IO_STATE_FUNCS_LSB 8
`define IO_STATE_OUTS_LSB 16

// Reset values.
`define RST_INPUT_SELECT 32'h88888888
`define RST_STATUS_ROUTE_GROUP_A 32'h00000000
`define RST_STATUS_ROUTE_GROUP_B 32'h00000000
`define RST_NEAR_ROUTE_SELECTOR 32'h00000000
`define RST_OUTPUT_INVERSION_BITS 32'h00000000
`define RST_CONTROL_MODE 32'h00000000

// Selector codes.
`define CODE_FORCE_ON 4'h7
`define CODE_FORCE_OFF 4'h8
`define CODE_INVERT_BASE 4'h9
`define CODE_LATCH_LOW_FIRST 4'h4
`define CODE_LATCH_HIGH_FIRST 4'hD

// Synchroniser depth.
`define SYNC_STAGES 3

`endif

/* File: logic/servo_io_pkg.sv */
package servo_io_pkg;
	typedef logic [3:0] in_code_t;
	typedef logic [1:0] route_t;
	typedef logic [6:0] pins_t;
	typedef logic [8:0] status_t;
	typedef enum logic [1:0] {
		MODE_POSITION = 2'h0,
		MODE_SPEED = 2'h1,
		MODE_TORQUE = 2'h2
	} control_mode_t;
endpackage

/* File: logic/pin_synchroniser.sv */
`include "servo_io_params.svh"

module pin_synchroniser (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Raw pins and filtered levels.
	input wire servo_io_pkg::pins_t pin_raw,
	output servo_io_pkg::pins_t pin_level
);
	import servo_io_pkg::*;

	genvar i;
	generate
		for (i = 0; i < 7; i = i + 1) begin : g_bit
			logic [`SYNC_STAGES-1:0] stage;
			logic level;
			logic next_level;
			always_comb begin
				next_level = level;
				if (stage[1] == stage[2]) begin
					next_level = stage[2];
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stage <= 3'h0;
					level <= 1'b0;
				end else begin
					stage <= {stage[1:0], pin_raw[i]};
					level <= next_level;
				end
			end
			assign pin_level[i] = level;
		end
	endgenerate
endmodule

/* File: tb/servo_io_checker_asserts.sv */
module servo_io_checker (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and functions.
	input wire servo_io_pkg::pins_t seq_in,
	input wire servo_io_pkg::status_t status_in,
	input wire logic forward_overtravel_in,
	input wire logic reverse_overtravel_in,
	input wire logic forward_torque_clamp_in,
	input wire logic latch_trigger_1,
	input wire logic latch_trigger_3,
	input wire logic [2:0] seq_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import servo_io_pkg::*;
	logic [31:0] sel, next_sel;
	logic [2:0] inv, next_inv;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Shadow copies of the selector and inversion registers.
	always_comb begin
		next_sel = sel;
		next_inv = inv;
		for (int i = 0; i < 4; i++) begin
			if (psel && penable && pwrite && pstrb[i] && paddr == 12'h000) begin
				next_sel[8*i +: 8] = pwdata[8*i +: 8];
			end
		end
		if (psel && penable && pwrite && pstrb[0] && paddr == 12'h010) begin
			next_inv = pwdata[2:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel <= 32'h88888888;
			inv <= 3'h0;
		end else begin
			sel <= next_sel;
			inv <= next_inv;
		end
	end
	a_ready_always: assert property (pready)
		else $error("pready low");
	a_bus_error: assert property (psel && penable |-> pslverr == !(paddr[1:0] == 2'h0 && paddr <= 12'h018))
		else $error("pslverr wrong");
	a_force_on: assert property ((sel[3:0] == 4'h7) [*2] |-> forward_overtravel_in)
		else $error("forced function inactive");
	a_force_off: assert property ((sel[31:28] == 4'h8) [*2] |-> !latch_trigger_3)
		else $error("forced-off function active");
	a_latch_refused: assert property ((sel[23:20] inside {[4'h0:4'h3], [4'h9:4'hC]}) [*2] |-> !latch_trigger_1)
		else $error("latch routed from a refused code");
	a_clamp_low: assert property ((sel[11:8] == 4'h0 && !seq_in[0]) [*6] |-> forward_torque_clamp_in)
		else $error("low pin not active for clamp");
	a_ot_inverted: assert property ((sel[7:4] == 4'h9 && seq_in[0]) [*6] |-> !reverse_overtravel_in)
		else $error("inverted overtravel wrong");
	a_inv_idle: assert property ((inv[2] && status_in == 9'h000) [*3] |-> seq_out[2])
		else $error("inverted idle pair low");
	a_plain_idle: assert property ((!inv[0] && status_in == 9'h000) [*3] |-> !seq_out[0])
		else $error("idle pair high");
	a_out_steady: assert property ((!psel && $stable(status_in)) [*3] |-> $stable(seq_out))
		else $error("pairs moved without cause");
	c_latch: cover property (latch_trigger_1);
	c_inverted: cover property (inv[2] && seq_out[2]);
	c_error: cover property (pslverr);
endmodule

bind servo_io_signal_allocator servo_io_checker u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .seq_in(seq_in), .status_in(status_in),
	.forward_overtravel_in(forward_overtravel_in), .reverse_overtravel_in(reverse_overtravel_in),
	.forward_torque_clamp_in(forward_torque_clamp_in), .latch_trigger_1(latch_trigger_1),
	.latch_trigger_3(latch_trigger_3), .seq_out(seq_out)
);

/* File: tb/host_io_model.sv */
module host_io_model (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Contact commands and connector pins.
	input wire servo_io_pkg::pins_t pin_cmd,
	output servo_io_pkg::pins_t seq_in
);
	timeunit 1ns;
	timeprecision 1ns;
	import servo_io_pkg::*;
	// The host switches its contacts on the clock edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_in <= 7'h00;
		end else begin
			seq_in <= pin_cmd;
		end
	end
endmodule

/* File: tb/servo_io_signal_allocator_test.sv */
module servo_io_signal_allocator_test;
	timeunit 1ns;
	timeprecision 1ns;
	import servo_io_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd_data;
	logic pready, pslverr, rd_err;
	pins_t pin_cmd = 7'h00;
	pins_t seq_in;
	status_t status_in = 9'h1FF;
	logic [7:0] funcs;
	logic [2:0] seq_out;
	int num_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	always #10 pclk = ~pclk;
	host_io_model u_host (.pclk(pclk), .presetn(presetn), .pin_cmd(pin_cmd), .seq_in(seq_in));
	servo_io_signal_allocator u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_in(seq_in),
		.status_in(status_in), .forward_overtravel_in(funcs[0]), .reverse_overtravel_in(funcs[1]),
		.forward_torque_clamp_in(funcs[2]), .reverse_torque_clamp_in(funcs[3]), .homing_slowdown_in(funcs[4]),
		.latch_trigger_1(funcs[5]), .latch_trigger_2(funcs[6]), .latch_trigger_3(funcs[7]), .seq_out(seq_out)
	);
	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_bits(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [7:0] fn_exp(input logic [3:0] c, input pins_t p);
		logic lvl, hi, lo;
		lvl = p[(c >= 4'h9) ? c - 4'h9 : c];
		hi = lvl ^ (c >= 4'h9);
		lo = lvl ^ (c < 4'h9);
		if (c == 4'h7) return 8'hFF;
		if (c == 4'h8) return 8'h00;
		return {(c inside {[4'h4:4'h6], [4'hD:4'hF]}) ? {3{lo}} : 3'h0, {3{lo}}, {2{hi}}};
	endfunction
	function automatic logic [2:0] pair_exp(input status_t st, input int m, input int v);
		status_t ok;
		ok = st & ((m == 0) ? 9'h1DD : (m == 1) ? 9'h0DE : (m == 2) ? 9'h0FC : 9'h1FF);
		return {|(ok & 9'h124), |(ok & 9'h092), |(ok & 9'h049)} ^ ((v != 0) ? 3'h6 : 3'h0);
	endfunction
	task automatic test_done;
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			test_done;
		end
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 7; a++) begin
			apb(1'b0, 12'(4 * a), 32'h00000000);
			check_word("reset value", (a == 0) ? 32'h88888888 : 32'h00000000, rd_data);
		end
		check_bits("functions at reset", 8'h00, funcs);
		check_bits("unrouted pairs", 8'h00, {5'h00, seq_out});
		apb(1'b0, 12'h01C, 32'h00000000);
		check_word("unmapped read", 32'h00000000, rd_data);
		check_bits("unmapped error", 8'h01, {7'h00, rd_err});
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, 12'h000, {8{c[3:0]}});
			for (int k = 0; k < 2; k++) begin
				pin_cmd <= (k == 1) ? 7'h2A : 7'h55;
				repeat (7) @(posedge pclk);
				check_bits("functions", fn_exp(c[3:0], pin_cmd), funcs);
			end
		end
		apb(1'b1, 12'h000, 32'h88888888);
		apb(1'b0, 12'h018, 32'h00000000);
		check_word("io state", 32'h0000002A, rd_data);
		apb(1'b1, 12'h004, 32'h00000079);
		apb(1'b1, 12'h008, 32'hFFFFFF9E);
		apb(1'b1, 12'h00C, 32'h00000003);
		apb(1'b0, 12'h008, 32'h00000000);
		check_word("route readback", 32'h0000009E, rd_data);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 12'h014, 32'(m));
			for (int v = 0; v < 2; v++) begin
				apb(1'b1, 12'h010, (v == 1) ? 32'h00000006 : 32'h00000000);
				for (int s = 0; s < 11; s++) begin
					status_in <= (s < 9) ? status_t'(1 << s) : ((s == 9) ? 9'h1FF : 9'h000);
					repeat (4) @(posedge pclk);
					check_bits("pairs", {5'h00, pair_exp(status_in, m, v)}, {5'h00, seq_out});
				end
			end
		end
		test_done;
	end
endmodule
